// File: pkg/sac_pkg.sv
// Shared constants and types of the converter control register block
package sac_pkg;

   // Wishbone geometry: 32-bit data, byte address
   localparam int unsigned SAC_ADR_W = 14;
   localparam int unsigned SAC_DAT_W = 32;

   // Register indices; the byte address is four times the index
   localparam logic [11:0] SAC_IDX_CTRL     = 12'hf70;
   localparam logic [11:0] SAC_IDX_RES_HIGH = 12'hf72;
   localparam logic [11:0] SAC_IDX_RES_LOW  = 12'hf73;
   localparam logic [11:0] SAC_IDX_SETTLE   = 12'hf74;
   localparam logic [11:0] SAC_IDX_SAMPLE   = 12'hf75;
   localparam logic [11:0] SAC_IDX_PRESCALE = 12'hf76;

   // Control register fields
   localparam int unsigned SAC_START_BIT = 7;
   localparam int unsigned SAC_REF_BIT   = 5;
   localparam int unsigned SAC_POWER_BIT = 4;
   localparam int unsigned SAC_CHAN_MSB  = 2;

   // Prescale fields
   localparam int unsigned SAC_HALVE_BIT   = 0;
   localparam int unsigned SAC_QUARTER_BIT = 1;
   localparam int unsigned SAC_EIGHTH_BIT  = 2;

   // Values after reset
   localparam logic [3:0] SAC_SETTLE_RST   = 4'hf;
   localparam logic [5:0] SAC_SAMPLE_RST   = 6'h3f;
   localparam logic [2:0] SAC_PRESCALE_RST = 3'h0;

   // Converter clock periods of the conversion phase
   localparam logic [3:0] SAC_CONV_CYCLES = 4'hd;

   // Least analog times software has to meet, and their cycle counts
   localparam int unsigned SAC_CLK_PERIOD_NS  = 5;
   localparam int unsigned SAC_SAMPLE_MIN_NS  = 1000;
   localparam int unsigned SAC_SETTLE_MIN_NS  = 500;
   localparam int unsigned SAC_SAMPLE_MIN_CYC =
      (SAC_SAMPLE_MIN_NS + SAC_CLK_PERIOD_NS - 1) / SAC_CLK_PERIOD_NS;
   localparam int unsigned SAC_SETTLE_MIN_CYC =
      (SAC_SETTLE_MIN_NS + SAC_CLK_PERIOD_NS - 1) / SAC_CLK_PERIOD_NS;

   // Divider terminal counts (divisor minus one)
   localparam logic [2:0] SAC_DIV1_LAST = 3'h0;
   localparam logic [2:0] SAC_HALVE_CLOCK_LAST = 3'h1;
   localparam logic [2:0] SAC_QUARTER_CLOCK_LAST = 3'h3;
   localparam logic [2:0] SAC_EIGHTH_CLOCK_LAST = 3'h7;

   typedef enum logic [3:0] {
      PH_IDLE    = 4'b0001,
      PH_SAMPLE  = 4'b0010,
      PH_SETTLE  = 4'b0100,
      PH_CONVERT = 4'b1000
   } sac_phase_t;

   // Controls toward the analog core
   typedef struct packed {
      logic       power_on;
      logic       ref_on;
      logic [2:0] chan;
      logic       sample;
      logic       hold;
      logic       start_conv;
   } sac_core_ctl_t;

   // State of the register block apart from the clock divider
   typedef struct packed {
      sac_phase_t    phase;
      logic [5:0]    cnt;
      logic [3:0]    conv_cnt;
      sac_core_ctl_t core;
      logic [3:0]    settle;
      logic [5:0]    sample;
      logic [2:0]    prescale;
      logic [9:0]    result;
      logic [1:0]    low;
      logic          ack;
      logic [7:0]    rdata;
      logic          irq;
   } sac_state_t;

endpackage

// File: verilog/sac_clk_div.sv
// Converter clock divider producing a one-cycle tick per converter period
`timescale 1ns/100ps
`default_nettype none
module sac_clk_div
   import sac_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       restart_i,
   input  wire logic [2:0] last_i,
   output logic            tick_o
);
   import sac_pkg::*;

   typedef struct packed {
      logic [2:0] cnt;
      logic       tick;
   } sac_div_state_t;

   sac_div_state_t s;
   sac_div_state_t n;

   always_comb begin
      n = s;
      // Wrap also when the divisor shrinks below the running count
      if (restart_i || s.cnt >= last_i) begin
         n.cnt = 3'h0;
      end else begin
         n.cnt = s.cnt + 3'h1;
      end
      n.tick = (n.cnt == last_i); // R15
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign tick_o = s.tick;

   a_undivided_tick: assert property (@(posedge clk_i) disable iff (rst_i) // R15
      (last_i == SAC_DIV1_LAST) [*2] |-> tick_o)
      else $error("undivided converter clock missed a cycle");

endmodule
`default_nettype wire

// File: verilog/sac_adc_ctrl.sv
// Control, timing and result registers of the eight-channel converter
//
// Behaviour
// R1 - Writing one to start launches a conversion; start reads one while busy
// R2 - Writing zero to start does nothing; start reads zero when idle
// R3 - Control bit 5 switches the internal reference on, else external
// R4 - Control bit 4 powers the converter; zero keeps it in low power
// R5 - Channel field bits 2..0 route analog input n to the converter
// R6 - Software writes zero to control bits 6 and 3
// R7 - Result high byte reads the upper eight result bits
// R8 - Reading the high byte latches the two low result bits
// R9 - Result stays unchanged until the next conversion finishes
// R10 - Low-bits register shows the two low result bits in bits 7..6
// R11 - Settle field sets clocks from sample-hold to conversion start; resets all ones
// R12 - Software sets settle count for at least half a microsecond
// R13 - Sample field sets sampling clocks after start; resets all ones
// R14 - Software sets sample count for at least one microsecond
// R15 - Prescale zero gives converter clock equal to system clock
// R16 - Prescale bits divide by 2, 4, 8; divide-by-8 has priority
// R17 - Software writes zero to reserved upper timing register bits
// R18 - Conversion phase lasts exactly thirteen converter clock periods
// R19 - A new start aborts any running conversion and restarts it
// R20 - Completion raises an interrupt request; power-down does not cancel it
// R21 - At the end busy clears, result loads and request fires together
// R22 - Sampling starts the cycle after start; settle then thirteen-cycle conversion
`timescale 1ns/100ps
`default_nettype none
module sac_adc_ctrl
   import sac_pkg::*;
(
   input  wire logic                  clk_i,
   input  wire logic                  rst_i,
   input  wire logic                  wb_cyc_i,
   input  wire logic                  wb_stb_i,
   input  wire logic                  wb_we_i,
   input  wire logic [SAC_ADR_W-1:0]  wb_adr_i,
   input  wire logic [3:0]            wb_sel_i,
   input  wire logic [SAC_DAT_W-1:0]  wb_dat_i,
   output logic      [SAC_DAT_W-1:0]  wb_dat_o,
   output logic                       wb_ack_o,
   input  wire logic [9:0]            conv_result_i,
   output sac_pkg::sac_core_ctl_t     core_o,
   output logic                       converter_clock_o,
   output logic                       irq_o
);
   import sac_pkg::*;

   sac_state_t s;
   sac_state_t n;

   logic [11:0] idx;
   logic        req;
   logic        commit;
   logic        wr_commit;
   logic        rd_commit;
   logic        busy;
   logic        restart;
   logic [2:0]  div_last;

   assign idx       = wb_adr_i[SAC_ADR_W-1:2];
   assign req       = wb_cyc_i & wb_stb_i;
   assign commit    = req & s.ack;
   // Writes land only on the low byte lane
   assign wr_commit = commit & wb_we_i & wb_sel_i[0];
   assign rd_commit = commit & ~wb_we_i;
   assign busy      = (s.phase != PH_IDLE);

   // Highest divisor bit wins
   always_comb begin
      if (s.prescale[SAC_EIGHTH_BIT]) begin // R16
         div_last = SAC_EIGHTH_CLOCK_LAST;
      end else if (s.prescale[SAC_QUARTER_BIT]) begin
         div_last = SAC_QUARTER_CLOCK_LAST;
      end else if (s.prescale[SAC_HALVE_BIT]) begin
         div_last = SAC_HALVE_CLOCK_LAST;
      end else begin
         div_last = SAC_DIV1_LAST; // R15
      end
   end

   sac_clk_div u_div (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .restart_i (restart),
      .last_i    (div_last),
      .tick_o    (converter_clock_o)
   );

   always_comb begin
      n                 = s;
      restart           = 1'b0;
      n.ack             = req & ~s.ack;
      n.irq             = 1'b0;
      n.core.start_conv = 1'b0;

      // Read data is captured with ack so it stands while ack is high
      if (req && !s.ack) begin
         case (idx)
            SAC_IDX_CTRL:     n.rdata = {busy, 1'b0, s.core.ref_on, s.core.power_on,
                                         1'b0, s.core.chan}; // R1 R2
            SAC_IDX_RES_HIGH: n.rdata = s.result[9:2]; // R7
            SAC_IDX_RES_LOW:  n.rdata = {s.low, 6'h00}; // R10
            SAC_IDX_SETTLE:   n.rdata = {4'h0, s.settle};
            SAC_IDX_SAMPLE:   n.rdata = {2'h0, s.sample};
            SAC_IDX_PRESCALE: n.rdata = {5'h00, s.prescale};
            default:          n.rdata = 8'h00;
         endcase
      end

      // Sequencer
      unique case (s.phase)
         PH_IDLE: begin
         end
         PH_SAMPLE: begin
            if (s.cnt <= 6'h01) begin // R13
               n.phase       = PH_SETTLE;
               n.cnt         = {2'h0, s.settle};
               n.core.sample = 1'b0;
               n.core.hold   = 1'b1; // R22
            end else begin
               n.cnt = s.cnt - 6'h01;
            end
         end
         PH_SETTLE: begin
            if (s.cnt <= 6'h01) begin // R11
               n.phase           = PH_CONVERT;
               n.conv_cnt        = SAC_CONV_CYCLES; // R18
               n.core.start_conv = 1'b1;
               restart           = 1'b1;
            end else begin
               n.cnt = s.cnt - 6'h01;
            end
         end
         PH_CONVERT: begin
            if (converter_clock_o) begin
               if (s.conv_cnt == 4'h1) begin // R21
                  n.phase     = PH_IDLE;
                  n.core.hold = 1'b0;
                  n.result    = conv_result_i; // R9
                  n.irq       = 1'b1; // R20
               end else begin
                  n.conv_cnt = s.conv_cnt - 4'h1; // R18
               end
            end
         end
         default: begin
            n.phase       = PH_IDLE;
            n.core.sample = 1'b0;
            n.core.hold   = 1'b0;
         end
      endcase

      // Register writes come after the sequencer so a start overrides it
      if (wr_commit) begin
         case (idx)
            SAC_IDX_CTRL: begin
               n.core.ref_on   = wb_dat_i[SAC_REF_BIT]; // R3
               n.core.power_on = wb_dat_i[SAC_POWER_BIT]; // R4
               n.core.chan     = wb_dat_i[SAC_CHAN_MSB:0]; // R5
               if (!wb_dat_i[SAC_POWER_BIT]) begin
                  // Power-down drops the run; a raised request still goes out
                  n.phase           = PH_IDLE; // R4
                  n.core.sample     = 1'b0;
                  n.core.hold       = 1'b0;
                  n.core.start_conv = 1'b0;
               end else if (wb_dat_i[SAC_START_BIT]) begin
                  n.phase           = PH_SAMPLE; // R1 R19 R22
                  n.cnt             = s.sample;
                  n.core.sample     = 1'b1;
                  n.core.hold       = 1'b0;
                  n.core.start_conv = 1'b0;
               end
            end
            SAC_IDX_SETTLE:   n.settle   = wb_dat_i[3:0]; // R11
            SAC_IDX_SAMPLE:   n.sample   = wb_dat_i[5:0]; // R13
            SAC_IDX_PRESCALE: n.prescale = wb_dat_i[2:0]; // R16
            default: begin
            end
         endcase
      end

      // Keeps high and low parts of one result together
      if (rd_commit && idx == SAC_IDX_RES_HIGH) begin
         n.low = s.result[1:0]; // R8
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s <= '{phase:    PH_IDLE,
                settle:   SAC_SETTLE_RST,
                sample:   SAC_SAMPLE_RST,
                prescale: SAC_PRESCALE_RST,
                default:  '0};
      end else begin
         s <= n;
      end
   end

   assign wb_dat_o = {24'h0000_00, s.rdata};
   assign wb_ack_o = s.ack;
   assign core_o   = s.core;
   assign irq_o    = s.irq;

   // Helper: cycles spent in the conversion phase
   logic [7:0] conv_len;
   logic [7:0] conv_expect;

   assign conv_expect = {4'h0, SAC_CONV_CYCLES} * ({5'h00, div_last} + 8'h01);

   always_ff @(posedge clk_i) begin
      if (rst_i || s.phase != PH_CONVERT) begin
         conv_len <= 8'h00;
      end else begin
         conv_len <= conv_len + 8'h01;
      end
   end

   logic wr_ctrl;
   logic issue;

   assign wr_ctrl = wr_commit && idx == SAC_IDX_CTRL;
   assign issue   = req && !s.ack;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   a_busy_reads_one: assert property ( // R1
      issue && idx == SAC_IDX_CTRL && !wb_we_i |=> wb_dat_o[7] == $past(busy))
      else $error("start bit does not show busy state");

   a_zero_write_idle: assert property ( // R2
      wr_ctrl && !wb_dat_i[SAC_START_BIT] && !busy |=> !busy)
      else $error("writing zero to start launched a conversion");

   a_reference_select: assert property ( // R3
      wr_ctrl |=> core_o.ref_on == $past(wb_dat_i[SAC_REF_BIT]))
      else $error("reference select not taken from write");

   a_power_down_stops: assert property ( // R4
      wr_ctrl && !wb_dat_i[SAC_POWER_BIT] |=> !busy && !core_o.power_on)
      else $error("power-down left converter running");

   a_channel_route: assert property ( // R5
      wr_ctrl |=> core_o.chan == $past(wb_dat_i[2:0]) [*1] ##1 $stable(core_o.chan)
         or ##1 wr_ctrl)
      else $error("channel select not routed");

   a_high_byte_read: assert property ( // R7
      issue && idx == SAC_IDX_RES_HIGH |=> wb_ack_o && wb_dat_o[7:0] == $past(s.result[9:2]))
      else $error("high byte read returned wrong bits");

   a_low_pair_latch: assert property ( // R8
      rd_commit && idx == SAC_IDX_RES_HIGH |=> s.low == $past(s.result[1:0]))
      else $error("low result bits not latched on high byte read");

   a_result_held: assert property ( // R9
      !(s.phase == PH_CONVERT && converter_clock_o && s.conv_cnt == 4'h1)
         |=> $stable(s.result))
      else $error("result changed without a finished conversion");

   a_low_bits_place: assert property ( // R10
      issue && idx == SAC_IDX_RES_LOW |=> wb_dat_o[7:6] == s.low && wb_dat_o[5:0] == 6'h00)
      else $error("low bits register layout wrong");

   a_conv_length: assert property ( // R18
      s.phase == PH_CONVERT ##1 s.phase == PH_IDLE && irq_o
         |-> $past(conv_len) + 8'h01 == conv_expect)
      else $error("conversion phase length wrong");

   a_restart_abort: assert property ( // R19
      wr_ctrl && wb_dat_i[SAC_START_BIT] && wb_dat_i[SAC_POWER_BIT] && busy
         |=> s.phase == PH_SAMPLE && core_o.sample && !core_o.hold)
      else $error("start did not restart a running conversion");

   a_done_together: assert property ( // R21
      $rose(irq_o) |-> $past(busy) && (!busy || $past(wr_ctrl))
         && s.result == $past(conv_result_i))
      else $error("completion request without busy clearing");

   a_sample_then_settle: assert property ( // R22
      wr_ctrl && wb_dat_i[SAC_START_BIT] && wb_dat_i[SAC_POWER_BIT]
         |=> core_o.sample ##[1:63] $fell(core_o.sample) && core_o.hold)
      else $error("sampling did not hand over to hold");

   c_full_conversion: cover property (
      s.phase == PH_SETTLE ##[1:300] irq_o);
   c_abort_restart: cover property (
      s.phase == PH_CONVERT && wr_ctrl && wb_dat_i[SAC_START_BIT]);
   c_high_byte_read: cover property (
      rd_commit && idx == SAC_IDX_RES_HIGH);
   c_divided_conv: cover property (
      s.prescale[SAC_EIGHTH_BIT] && irq_o);

endmodule
`default_nettype wire

// File: test/sac_core_model.sv
// Behavioural analog core answering conversions of the control block
`timescale 1ns/100ps
`default_nettype none
module sac_core_model
   import sac_pkg::*;
(
   input  wire logic                   clk_i,
   input  wire sac_pkg::sac_core_ctl_t core_i,
   output logic [9:0]                  result_o
);
   import sac_pkg::*;
   logic       valid;
   logic [9:0] value;
   initial begin
      valid = 1'b0;
      value = 10'h000;
   end
   // Code differs per channel so a wrong route shows; output toggles while no code is valid (before a start, after power-down)
   always @(posedge clk_i) begin
      if (core_i.start_conv) begin
         valid <= 1'b1;
         value <= 10'h2a5 ^ {7'h00, core_i.chan} ^ {core_i.chan, 7'h00};
      end else begin
         if (!core_i.power_on)
            valid <= 1'b0;
         if (!valid)
            value <= ~value;
      end
   end
   assign result_o = value;
endmodule
`default_nettype wire

// File: test/test_sac_adc_ctrl.sv
// Self-checking bench of the converter control register block
`timescale 1ns/100ps
`default_nettype none
module test_sac_adc_ctrl;
   import sac_pkg::*;
   logic          clk_i, rst_i, cyc, stb, we, ack, cclk, irq, conv_on;
   logic [13:0]   adr;
   logic [3:0]    sel;
   logic [31:0]   dat, dat_o;
   logic [9:0]    res;
   sac_core_ctl_t core;
   int            n_mismatch, n_compared, n_samp, n_settle, n_conv, n_irq;

   sac_adc_ctrl i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
      .wb_ack_o(ack), .conv_result_i(res), .core_o(core), .converter_clock_o(cclk),
      .irq_o(irq));
   sac_core_model i_core (.clk_i(clk_i), .core_i(core), .result_o(res));

   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end

   // Phase lengths seen at the core controls
   always @(posedge clk_i) begin
      n_samp += core.sample;
      if (core.hold && !conv_on && !core.start_conv) n_settle++;
      if (irq) begin
         n_irq++;
         conv_on = 1'b0;
      end
      if (core.start_conv) conv_on = 1'b1;
      if (conv_on) n_conv++;
   end

   function automatic logic [9:0] code(input logic [2:0] c);
      return 10'h2a5 ^ {7'h00, c} ^ {c, 7'h00};
   endfunction

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wb(input logic w, input logic [11:0] idx, input logic [7:0] d,
                     output logic [31:0] q);
      int n;
      @(posedge clk_i);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= {idx, 2'b00}; dat <= {24'h00_0000, d};
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1);
      q = dat_o;
      cyc <= 1'b0; stb <= 1'b0;
   endtask

   task automatic wait_irq();
      for (int n = 0; n < 400 && n_irq == 0; n++) @(posedge clk_i);
   endtask

   task automatic clr();
      n_samp = 0; n_settle = 0; n_conv = 0; n_irq = 0;
   endtask

   task automatic t_reset();
      logic [31:0] q;
      wb(0, SAC_IDX_CTRL, 8'h00, q); chk("ctrl", 32'h0000_0000, q);
      wb(0, SAC_IDX_SETTLE, 8'h00, q); chk("settle", 32'h0000_000f, q);
      wb(0, SAC_IDX_SAMPLE, 8'h00, q); chk("sample", 32'h0000_003f, q);
      wb(0, SAC_IDX_PRESCALE, 8'h00, q); chk("prescale", 32'h0000_0000, q);
      wb(0, 12'hf71, 8'h00, q); chk("unmapped", 32'h0000_0000, q);
   endtask

   // Every channel code and both enables, start bit left zero
   task automatic t_fields();
      logic [31:0] q;
      logic [7:0]  v;
      for (int i = 0; i < 8; i++) begin
         v = {2'b00, i[0], i[1], 1'b0, i[2:0]};
         wb(1, SAC_IDX_CTRL, v, q);
         wb(0, SAC_IDX_CTRL, 8'h00, q); chk("ctrl", {24'h00_0000, v}, q);
         chk("chan", {29'h0, i[2:0]}, {29'h0, core.chan});
         chk("ref", {31'h0, i[0]}, {31'h0, core.ref_on});
         chk("power", {31'h0, i[1]}, {31'h0, core.power_on});
      end
      chk("idle sample", 32'h0, {31'h0, core.sample});
      // Fields cannot reach the analog minimums at this clock; short runs instead
      wb(1, SAC_IDX_SAMPLE, 8'h02, q);
      wb(1, SAC_IDX_SETTLE, 8'h03, q);
      wb(0, SAC_IDX_SETTLE, 8'h00, q); chk("settle", 32'h0000_0003, q);
   endtask

   // One conversion per divider setting, overlapping bits included
   task automatic t_conv();
      logic [31:0] q;
      logic [2:0]  ps [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h3, 3'h7};
      int          dv [6] = '{1, 2, 4, 8, 4, 8};
      logic [2:0]  c;
      logic [9:0]  r;
      for (int i = 0; i < 6; i++) begin
         c = i[2:0];
         r = code(c);
         wb(1, SAC_IDX_PRESCALE, {5'h00, ps[i]}, q);
         clr();
         wb(1, SAC_IDX_CTRL, {5'h12, c}, q);
         wb(0, SAC_IDX_CTRL, 8'h00, q); chk("busy", {24'h0, 5'h12, c}, q);
         wait_irq();
         chk("irqs", 1, n_irq);
         chk("sample len", 2, n_samp);
         chk("settle len", 3, n_settle);
         chk("conv len", 13 * dv[i], n_conv);
         wb(0, SAC_IDX_CTRL, 8'h00, q); chk("done", {24'h0, 5'h02, c}, q);
         wb(0, SAC_IDX_RES_HIGH, 8'h00, q); chk("high", {24'h0, r[9:2]}, q);
         wb(0, SAC_IDX_RES_LOW, 8'h00, q); chk("low", {24'h0, r[1:0], 6'h00}, q);
      end
   endtask

   // Old result stands during a conversion; low bits follow high reads only
   task automatic t_hold();
      logic [31:0] q;
      logic [9:0]  o;
      logic [9:0]  w;
      o = code(3'd5);
      w = code(3'd6);
      clr();
      wb(1, SAC_IDX_CTRL, 8'h96, q);
      wb(0, SAC_IDX_RES_HIGH, 8'h00, q); chk("old high", {24'h0, o[9:2]}, q);
      wait_irq();
      wb(0, SAC_IDX_RES_LOW, 8'h00, q); chk("held low", {24'h0, o[1:0], 6'h00}, q);
      wb(0, SAC_IDX_RES_HIGH, 8'h00, q); chk("new high", {24'h0, w[9:2]}, q);
      wb(0, SAC_IDX_RES_LOW, 8'h00, q); chk("new low", {24'h0, w[1:0], 6'h00}, q);
   endtask

   // Second start in mid-sequence restarts; only one completion follows
   task automatic t_abort();
      logic [31:0] q;
      logic [9:0]  r;
      r = code(3'd3);
      clr();
      wb(1, SAC_IDX_CTRL, 8'h91, q);
      repeat (20) @(posedge clk_i);
      wb(1, SAC_IDX_CTRL, 8'h93, q);
      wait_irq();
      repeat (150) @(posedge clk_i);
      chk("abort irqs", 1, n_irq);
      wb(0, SAC_IDX_RES_HIGH, 8'h00, q); chk("abort high", {24'h0, r[9:2]}, q);
   endtask

   task automatic tally_and_finish();
      if (n_mismatch == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Whole run takes well under a fifth of this span
   initial begin
      #100000;
      n_mismatch++;
      tally_and_finish();
   end

   initial begin
      rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 14'h0000;
      sel = 4'h1; dat = 32'h0000_0000; conv_on = 1'b0;
      n_mismatch = 0; n_compared = 0;
      clr();
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_fields();
      t_conv();
      t_hold();
      t_abort();
      tally_and_finish();
   end
endmodule
`default_nettype wire
